/* File: hdl/sqc_seq_ctrl.sv */
// Sequence controller for a successive approximation converter.
`timescale 1ns/10ps
// What this block does
// - Two conversion sequences, each with its own trigger choice.
// - Software starts and hardware triggers both work, mixed freely.
// - Enabled sequence converts one sample per trigger until disabled.
// - Converter input multiplexed among up to twelve channels.
// - Three interrupt outputs: sequence one, sequence two, threshold.
// - Threshold interrupt fires on threshold hit or data overrun.
// - Optional high and low threshold compare with low threshold crossing.
// - Register port always runs on the system clock.
// - Synchronous mode divides the system clock for conversion timing.
// - Asynchronous mode uses the independent clock undivided.
// - Asynchronous mode synchronises hardware triggers, adding latency.
// - A full accuracy conversion takes fifteen conversion clocks.
// - Input select value 3 routes temperature sensor; 0 restores pin.
// - Temperature reading arrives as an ordinary channel zero result.
// - Two pin trigger inputs, selectable by either sequence control.
// - Result is a linear twelve bit code, full scale 4095.
// - Result saturates at zero below and, above references, at the top code of the resolution: 0xfff at twelve bits.
// - Burst mode repeats conversions; lower resolutions convert faster.
module sqc_seq_ctrl
  import sqc_pkg::*;
#(
  parameter int NUM_CHAN = 12
) (
  input  wire logic        REF_CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [31:0] WR_DATA_IN,
  input  wire logic        WR_EN_IN,
  input  wire logic        RD_EN_IN,
  input  wire logic [1:0]  PIN_TRIG_IN,
  input  wire logic        CONV_CLK_IN,
  input  wire logic        COMP_IN,
  output logic [31:0]      RD_DATA_OUT,
  output logic [3:0]       CHAN_SEL_OUT,
  output logic             TEMP_SEL_OUT,
  output logic             SAMPLE_OUT,
  output logic [11:0]      DAC_CODE_OUT,
  output logic             BUSY_OUT,
  output logic             SEQ0_IRQ_OUT,
  output logic             SEQ1_IRQ_OUT,
  output logic             THCMP_IRQ_OUT
);

  // ---------------------------------------------------------------
  // State of the whole block
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                 div;
    logic                       async_mode;
    logic [1:0]                 res;
    logic [1:0]                 insrc;
    logic [1:0]                 seq_en;
    logic [1:0]                 seq_burst;
    logic [1:0][1:0]            seq_trig;
    logic [1:0][NUM_CHAN-1:0]   seq_mask;
    logic [1:0][3:0]            seq_ptr;
    logic [1:0]                 pend;
    logic [1:0][11:0]           thr_lo;
    logic [1:0][11:0]           thr_hi;
    logic [NUM_CHAN-1:0]        thrsel;
    logic [3:0]                 inten;
    logic [1:0]                 seq_flag;
    logic [NUM_CHAN-1:0]        thcmp;
    logic [NUM_CHAN-1:0]        ovr;
    logic [NUM_CHAN-1:0]        below;
    logic [NUM_CHAN-1:0]        seen;
    logic [NUM_CHAN-1:0][11:0]  res_code;
    logic [NUM_CHAN-1:0]        done;
    logic [1:0][11:0]           gcode;
    logic [1:0][3:0]            gchan;
    logic [1:0]                 pin_prev;
    logic [1:0]                 trig_s1;
    logic [1:0]                 trig_s2;
    logic [1:0]                 trig_s3;
    logic                       cclk_s1;
    logic                       cclk_s2;
    logic                       cclk_s3;
    logic [7:0]                 div_cnt;
    sqc_state_t                 state;
    logic                       cur_seq;
    logic [3:0]                 cur_chan;
    logic [3:0]                 bit_idx;
    logic [3:0]                 cyc;
    logic [11:0]                sar;
    logic [31:0]                rdata;
    logic [2:0]                 irq;
  } sqc_regs_t;

  sqc_regs_t q_ff;
  sqc_regs_t nxt_q;

  // Picks the next enabled channel at or after a start point.
  function automatic logic [3:0] next_chan(
    input logic [NUM_CHAN-1:0] mask,
    input logic [3:0]          from
  );
    logic [3:0] pick;
    logic       found;
    int         j;
    pick  = from;
    found = 1'b0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      j = (int'(from) + i) % NUM_CHAN;
      if (!found && mask[j]) begin
        pick  = 4'(j);
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  // Tells whether an address falls on a per-channel data register.
  function automatic logic is_dat(input logic [7:0] a);
    return (a >= OFS_DAT0) && (a < OFS_DAT0 + 8'(4 * NUM_CHAN));
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Bus writes and read side effects are applied first so that a
  // hardware event later in the same cycle wins over a clear.
  always_comb begin
    logic        tick;
    logic [1:0]  edge_hit;
    logic [1:0]  hw_hit;
    logic [1:0]  sw_go;
    logic [3:0]  ch;
    logic [3:0]  low_bit;
    logic [3:0]  didx;
    logic        s;
    logic        p;
    logic        commit;
    logic [11:0] code;
    tick     = 1'b0;
    edge_hit = 2'b00;
    hw_hit   = 2'b00;
    sw_go    = 2'b00;
    ch       = 4'h0;
    low_bit  = 4'({~q_ff.res, 1'b0});
    didx     = 4'((ADDR_IN - OFS_DAT0) >> 2);
    s        = 1'b0;
    p        = 1'b0;
    commit   = 1'b0;
    code     = q_ff.sar;
    nxt_q    = q_ff;

    // Register writes.
    if (WR_EN_IN) begin
      unique case (ADDR_IN)
        OFS_CTRL: begin
          nxt_q.div        = WR_DATA_IN[7:0];
          nxt_q.async_mode = WR_DATA_IN[CTRL_ASYNC_BIT];
          nxt_q.res        = WR_DATA_IN[CTRL_RES_LSB +: 2];
        end
        OFS_INSRC:  nxt_q.insrc = WR_DATA_IN[1:0];
        OFS_SEQ0, OFS_SEQ1: begin
          s = ADDR_IN[2];
          nxt_q.seq_mask[s]  = WR_DATA_IN[NUM_CHAN-1:0];
          nxt_q.seq_trig[s]  = WR_DATA_IN[SEQ_TRIG_LSB +: 2];
          nxt_q.seq_burst[s] = WR_DATA_IN[SEQ_BURST_BIT];
          nxt_q.seq_en[s]    = WR_DATA_IN[SEQ_EN_BIT];
          sw_go[s] = WR_DATA_IN[SEQ_START_BIT];
        end
        OFS_THLO0, OFS_THLO1: nxt_q.thr_lo[ADDR_IN[2]] = WR_DATA_IN[11:0];
        OFS_THHI0, OFS_THHI1: nxt_q.thr_hi[ADDR_IN[2]] = WR_DATA_IN[11:0];
        OFS_THRSEL: nxt_q.thrsel = WR_DATA_IN[NUM_CHAN-1:0];
        OFS_INTEN:  nxt_q.inten  = WR_DATA_IN[3:0];
        OFS_FLAGS: begin
          // Flags clear by writing ones.
          nxt_q.thcmp    = q_ff.thcmp & ~WR_DATA_IN[NUM_CHAN-1:0];
          nxt_q.ovr      = q_ff.ovr & ~WR_DATA_IN[FLG_OVR_LSB +: NUM_CHAN];
          nxt_q.seq_flag = q_ff.seq_flag & ~WR_DATA_IN[FLG_SEQ_LSB +: 2];
        end
        default: ;
      endcase
    end

    // Register reads; a data register read retires its done bit.
    nxt_q.rdata = 32'h0000_0000;
    if (RD_EN_IN) begin
      if (is_dat(ADDR_IN)) begin
        nxt_q.rdata[DAT_RES_LSB +: 12]  = q_ff.res_code[didx];
        nxt_q.rdata[DAT_CHAN_LSB +: 4]  = didx;
        nxt_q.rdata[DAT_OVR_BIT]        = q_ff.ovr[didx];
        nxt_q.rdata[DAT_DONE_BIT]       = q_ff.done[didx];
        nxt_q.done[didx]                = 1'b0;
      end else begin
        unique case (ADDR_IN)
          OFS_CTRL: nxt_q.rdata = {21'h0, q_ff.res, q_ff.async_mode,
                                   q_ff.div};
          OFS_INSRC: nxt_q.rdata[1:0] = q_ff.insrc;
          OFS_SEQ0, OFS_SEQ1: begin
            s = ADDR_IN[2];
            nxt_q.rdata[NUM_CHAN-1:0]       = q_ff.seq_mask[s];
            nxt_q.rdata[SEQ_TRIG_LSB +: 2]  = q_ff.seq_trig[s];
            nxt_q.rdata[SEQ_BURST_BIT]      = q_ff.seq_burst[s];
            nxt_q.rdata[SEQ_EN_BIT]         = q_ff.seq_en[s];
          end
          OFS_GRES0, OFS_GRES1: begin
            s = ADDR_IN[2];
            nxt_q.rdata[DAT_RES_LSB +: 12] = q_ff.gcode[s];
            nxt_q.rdata[DAT_CHAN_LSB +: 4] = q_ff.gchan[s];
            nxt_q.rdata[DAT_DONE_BIT]      = q_ff.seq_flag[s];
          end
          OFS_THLO0, OFS_THLO1: nxt_q.rdata[11:0] = q_ff.thr_lo[ADDR_IN[2]];
          OFS_THHI0, OFS_THHI1: nxt_q.rdata[11:0] = q_ff.thr_hi[ADDR_IN[2]];
          OFS_THRSEL: nxt_q.rdata[NUM_CHAN-1:0] = q_ff.thrsel;
          OFS_INTEN:  nxt_q.rdata[3:0] = q_ff.inten;
          OFS_FLAGS: begin
            nxt_q.rdata[NUM_CHAN-1:0]          = q_ff.thcmp;
            nxt_q.rdata[FLG_OVR_LSB +: NUM_CHAN] = q_ff.ovr;
            nxt_q.rdata[FLG_SEQ_LSB +: 2]      = q_ff.seq_flag;
            nxt_q.rdata[FLG_THANY_BIT]         = |q_ff.thcmp;
            nxt_q.rdata[FLG_OVANY_BIT]         = |q_ff.ovr;
          end
          default: nxt_q.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Trigger capture. The async path waits two extra flops.
    nxt_q.pin_prev = PIN_TRIG_IN;
    nxt_q.trig_s1  = PIN_TRIG_IN;
    nxt_q.trig_s2  = q_ff.trig_s1;
    nxt_q.trig_s3  = q_ff.trig_s2;
    if (q_ff.async_mode) begin
      edge_hit = q_ff.trig_s2 & ~q_ff.trig_s3;
    end else begin
      edge_hit = PIN_TRIG_IN & ~q_ff.pin_prev;
    end

    // Conversion tick: divided system clock, or the sampled independent clock.
    nxt_q.cclk_s1 = CONV_CLK_IN;
    nxt_q.cclk_s2 = q_ff.cclk_s1;
    nxt_q.cclk_s3 = q_ff.cclk_s2;
    nxt_q.div_cnt = (q_ff.div_cnt >= q_ff.div) ? 8'h00 : q_ff.div_cnt + 8'h01;
    tick = q_ff.async_mode ? (q_ff.cclk_s2 & ~q_ff.cclk_s3)
                           : (q_ff.div_cnt >= q_ff.div);

    // Conversion engine.
    unique case (q_ff.state)
      SQC_IDLE: begin
        if (q_ff.pend[0] || q_ff.pend[1]) begin
          s = !q_ff.pend[0];
          nxt_q.pend[s] = 1'b0;
          if (q_ff.seq_mask[s] != '0) begin
            ch = next_chan(q_ff.seq_mask[s], q_ff.seq_ptr[s]);
            nxt_q.cur_chan = ch;
            nxt_q.cur_seq  = s;
            nxt_q.seq_ptr[s] = (ch == 4'(NUM_CHAN - 1)) ? 4'h0 : ch + 4'h1;
            nxt_q.cyc   = 4'h0;
            nxt_q.state = SQC_SAMPLE;
          end
        end
      end
      SQC_SAMPLE: begin
        if (tick) begin
          nxt_q.cyc = q_ff.cyc + 4'h1;
          if (q_ff.cyc == SAMPLE_TICKS - 4'h1) begin
            nxt_q.bit_idx = 4'hb;
            nxt_q.sar     = SAR_MSB_CODE;
            nxt_q.state   = SQC_CONVERT;
          end
        end
      end
      SQC_CONVERT: begin
        // One decision per tick; keeps the trial bit only if the input
        // is at or above it, so the code clamps at 0 and at ones down to low_bit, 0xfff at twelve bits.
        if (tick) begin
          if (!COMP_IN) begin
            nxt_q.sar[q_ff.bit_idx] = 1'b0;
          end
          if (q_ff.bit_idx == low_bit) begin
            nxt_q.cyc   = 4'h0;
            nxt_q.state = SQC_FINISH;
          end else begin
            nxt_q.bit_idx = q_ff.bit_idx - 4'h1;
            nxt_q.sar[q_ff.bit_idx - 4'h1] = 1'b1;
          end
        end
      end
      SQC_FINISH: begin
        if (q_ff.cyc == 4'h0) begin
          nxt_q.cyc = {3'h0, tick};
        end else if (!q_ff.async_mode
                     || q_ff.cyc == RESULT_SYNC_CYC + 4'h1) begin
          commit = 1'b1;
          nxt_q.state = SQC_IDLE;
        end else begin
          nxt_q.cyc = q_ff.cyc + 4'h1;
        end
      end
    endcase

    // Result commit with compare, crossing and overrun checks.
    if (commit) begin
      ch = q_ff.cur_chan;
      p  = q_ff.thrsel[ch];
      nxt_q.ovr[ch] = nxt_q.ovr[ch] | q_ff.done[ch];
      nxt_q.res_code[ch] = code;
      nxt_q.done[ch]     = 1'b1;
      nxt_q.gcode[q_ff.cur_seq] = code;
      nxt_q.gchan[q_ff.cur_seq] = ch;
      nxt_q.seq_flag[q_ff.cur_seq] = 1'b1;
      nxt_q.below[ch] = (code < q_ff.thr_lo[p]);
      nxt_q.seen[ch]  = 1'b1;
      if (code < q_ff.thr_lo[p] || code > q_ff.thr_hi[p]
          || (q_ff.seen[ch] && q_ff.below[ch] != (code < q_ff.thr_lo[p])))
      begin
        nxt_q.thcmp[ch] = 1'b1;
      end
    end

    // Trigger bookkeeping per sequence, after the engine took one.
    for (int k = 0; k < 2; k++) begin
      hw_hit[k] = (q_ff.seq_trig[k] == TRIG_PIN0 && edge_hit[0])
               || (q_ff.seq_trig[k] == TRIG_PIN1 && edge_hit[1]);
      if (!nxt_q.seq_en[k]) begin
        nxt_q.pend[k] = 1'b0;
      end else if (hw_hit[k] || sw_go[k]) begin
        nxt_q.pend[k] = 1'b1;
      end else if (q_ff.seq_burst[k] && q_ff.state == SQC_IDLE) begin
        nxt_q.pend[k] = 1'b1;
      end
    end

    // Interrupt lines follow the flags gated by their enables.
    nxt_q.irq[0] = nxt_q.seq_flag[0] & nxt_q.inten[0];
    nxt_q.irq[1] = nxt_q.seq_flag[1] & nxt_q.inten[1];
    nxt_q.irq[2] = ((|nxt_q.thcmp) & nxt_q.inten[IEN_THCMP_BIT])
                 | ((|nxt_q.ovr) & nxt_q.inten[IEN_OVR_BIT]);
  end

  // ---------------------------------------------------------------
  // State register, on the system clock only
  // ---------------------------------------------------------------
  // The one clock carries both the register port and the engine.
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      q_ff            <= '0;
      q_ff.div        <= CTRL_DIV_RST;
      q_ff.async_mode <= CTRL_ASYNC_RST;
      q_ff.res        <= CTRL_RES_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Outputs come straight from the state register.
  assign RD_DATA_OUT   = q_ff.rdata;
  assign CHAN_SEL_OUT  = q_ff.cur_chan;
  assign TEMP_SEL_OUT  = (q_ff.insrc == INSRC_TEMP);
  assign SAMPLE_OUT    = (q_ff.state == SQC_SAMPLE);
  assign DAC_CODE_OUT  = q_ff.sar;
  assign BUSY_OUT      = (q_ff.state != SQC_IDLE);
  assign SEQ0_IRQ_OUT  = q_ff.irq[0];
  assign SEQ1_IRQ_OUT  = q_ff.irq[1];
  assign THCMP_IRQ_OUT = q_ff.irq[2];

endmodule

/* File: hdl/sqc_pkg.sv */
// Package of offsets, field positions, reset values and counts for sqc.
package sqc_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses on the register port)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_INSRC   = 8'h04;
  localparam logic [7:0] OFS_SEQ0    = 8'h08;
  localparam logic [7:0] OFS_SEQ1    = 8'h0c;
  localparam logic [7:0] OFS_GRES0   = 8'h10;
  localparam logic [7:0] OFS_GRES1   = 8'h14;
  localparam logic [7:0] OFS_DAT0    = 8'h20;
  localparam logic [7:0] OFS_THLO0   = 8'h50;
  localparam logic [7:0] OFS_THLO1   = 8'h54;
  localparam logic [7:0] OFS_THHI0   = 8'h58;
  localparam logic [7:0] OFS_THHI1   = 8'h5c;
  localparam logic [7:0] OFS_THRSEL  = 8'h60;
  localparam logic [7:0] OFS_INTEN   = 8'h64;
  localparam logic [7:0] OFS_FLAGS   = 8'h68;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_ASYNC_BIT = 8;
  localparam int CTRL_RES_LSB   = 9;
  localparam int SEQ_TRIG_LSB   = 12;
  localparam int SEQ_BURST_BIT  = 16;
  localparam int SEQ_START_BIT  = 26;
  localparam int SEQ_EN_BIT     = 31;
  localparam int DAT_RES_LSB    = 4;
  localparam int DAT_CHAN_LSB   = 26;
  localparam int DAT_OVR_BIT    = 30;
  localparam int DAT_DONE_BIT   = 31;
  localparam int FLG_OVR_LSB    = 12;
  localparam int FLG_SEQ_LSB    = 28;
  localparam int FLG_THANY_BIT  = 30;
  localparam int FLG_OVANY_BIT  = 31;
  localparam int IEN_THCMP_BIT  = 2;
  localparam int IEN_OVR_BIT    = 3;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_DIV_RST   = 8'h00;
  localparam logic        CTRL_ASYNC_RST = 1'b0;
  localparam logic [1:0]  CTRL_RES_RST   = 2'h3;
  localparam logic [1:0]  INSRC_TEMP     = 2'h3;
  localparam logic [1:0]  TRIG_PIN0      = 2'h1;
  localparam logic [1:0]  TRIG_PIN1      = 2'h2;
  localparam logic [11:0] SAR_MSB_CODE   = 12'h800;

  // ---------------------------------------------------------------
  // Timing counts, in conversion ticks or system clocks
  // ---------------------------------------------------------------
  localparam logic [3:0] SAMPLE_TICKS    = 4'h2;
  localparam logic [3:0] RESULT_SYNC_CYC = 4'h2;

  typedef enum logic [1:0] {
    SQC_IDLE    = 2'b00,
    SQC_SAMPLE  = 2'b01,
    SQC_CONVERT = 2'b10,
    SQC_FINISH  = 2'b11
  } sqc_state_t;

endpackage

/* File: tb/sqc_seq_ctrl_properties.sv */
// Port-level assertions for the converter sequence controller.
`timescale 1ns/10ps
module sqc_chk
  import sqc_pkg::*;
#(
  parameter int NUM_CHAN = 12
) (
  input wire logic        REF_CLK_IN,
  input wire logic        SYS_RST_IN,
  input wire logic [7:0]  ADDR_IN,
  input wire logic [31:0] WR_DATA_IN,
  input wire logic        WR_EN_IN,
  input wire logic        RD_EN_IN,
  input wire logic [1:0]  PIN_TRIG_IN,
  input wire logic        CONV_CLK_IN,
  input wire logic        COMP_IN,
  input wire logic [31:0] RD_DATA_OUT,
  input wire logic [3:0]  CHAN_SEL_OUT,
  input wire logic        TEMP_SEL_OUT,
  input wire logic        SAMPLE_OUT,
  input wire logic [11:0] DAC_CODE_OUT,
  input wire logic        BUSY_OUT,
  input wire logic        SEQ0_IRQ_OUT,
  input wire logic        SEQ1_IRQ_OUT,
  input wire logic        THCMP_IRQ_OUT
);
  localparam int MSB_WAIT = 64;
  logic [3:0] wr_age_ff;
  logic [3:0] bz_age_ff;

  // --------------------------------------------------------------
  // Cause ages
  // --------------------------------------------------------------
  // Cycles since the last write and busy cycle; saturating, so a long
  // idle stretch never wraps into a false cause.
  always_ff @(posedge REF_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      wr_age_ff <= 4'hf;
      bz_age_ff <= 4'hf;
    end else begin
      wr_age_ff <= WR_EN_IN ? 4'h0 : wr_age_ff + {3'h0, wr_age_ff != 4'hf};
      bz_age_ff <= BUSY_OUT ? 4'h0 : bz_age_ff + {3'h0, bz_age_ff != 4'hf};
    end
  end

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  // A conversion opens, then the top bit is tried within a bounded wait.
  sequence conv_start_s;
    $rose(BUSY_OUT);
  endsequence
  sequence msb_trial_s;
    ##[1:MSB_WAIT] DAC_CODE_OUT == SAR_MSB_CODE;
  endsequence

  rd_idle_zero_a: assert property (
    !$past(RD_EN_IN) |-> RD_DATA_OUT == 32'h0)
    else $error("Read data present without a read strobe.");
  sample_in_busy_a: assert property (
    SAMPLE_OUT |-> BUSY_OUT)
    else $error("Sample phase outside a conversion.");
  conv_opens_a: assert property (
    conv_start_s |-> SAMPLE_OUT)
    else $error("Conversion did not open with sampling.");
  msb_first_a: assert property (
    conv_start_s |-> msb_trial_s)
    else $error("Top bit trial code never shown.");
  chan_range_a: assert property (
    BUSY_OUT |-> CHAN_SEL_OUT < 4'(NUM_CHAN))
    else $error("Converted channel out of range.");
  chan_hold_a: assert property (
    BUSY_OUT && $past(BUSY_OUT) |-> $stable(CHAN_SEL_OUT))
    else $error("Channel changed inside a conversion.");
  temp_by_write_a: assert property (
    $changed(TEMP_SEL_OUT) |-> $past(WR_EN_IN) && $past(ADDR_IN) == OFS_INSRC)
    else $error("Sensor routing changed without a select write.");
  seq0_cause_a: assert property (
    $rose(SEQ0_IRQ_OUT) |-> bz_age_ff < 4'h8 || wr_age_ff < 4'h8)
    else $error("First sequence irq rose without a cause.");
  seq1_cause_a: assert property (
    $rose(SEQ1_IRQ_OUT) |-> bz_age_ff < 4'h8 || wr_age_ff < 4'h8)
    else $error("Second sequence irq rose without a cause.");
  thcmp_cause_a: assert property (
    $rose(THCMP_IRQ_OUT) |-> bz_age_ff < 4'h8 || wr_age_ff < 4'h8)
    else $error("Threshold irq rose without a cause.");
  irq_clear_a: assert property (
    $fell(SEQ0_IRQ_OUT) |-> wr_age_ff < 4'h4)
    else $error("First sequence irq fell without a write.");
endmodule

bind sqc_seq_ctrl sqc_chk #(.NUM_CHAN(NUM_CHAN)) u_sqc_chk (
  .REF_CLK_IN, .SYS_RST_IN, .ADDR_IN, .WR_DATA_IN, .WR_EN_IN, .RD_EN_IN,
  .PIN_TRIG_IN, .CONV_CLK_IN, .COMP_IN, .RD_DATA_OUT, .CHAN_SEL_OUT,
  .TEMP_SEL_OUT, .SAMPLE_OUT, .DAC_CODE_OUT, .BUSY_OUT, .SEQ0_IRQ_OUT,
  .SEQ1_IRQ_OUT, .THCMP_IRQ_OUT);

/* File: tb/sqc_adc_model.sv */
// Analog side model: input multiplexer, sample hold and comparator.
`timescale 1ns/10ps
module sqc_adc_model (
  input  wire logic              clk_in,
  input  wire logic [3:0]        chan_in,
  input  wire logic              temp_in,
  input  wire logic              sample_in,
  input  wire logic [11:0]       dac_in,
  input  wire logic [12:0][15:0] vin_in,
  output logic                   comp_out
);
  logic signed [15:0] pick;
  logic signed [15:0] held_ff = 16'sh0;

  // Channel zero carries the sensor while routed in; unpopulated
  // channels read as ground.
  always_comb begin
    if (chan_in == 4'h0 && temp_in) pick = vin_in[12];
    else if (chan_in < 4'hc) pick = vin_in[chan_in];
    else pick = 16'sh0;
  end

  // The input is tracked while sampling and held after, so all bit trials see one value.
  always @(posedge clk_in) begin
    if (sample_in) held_ff <= pick;
  end

  // Inputs beyond the references beat or lose every code: 0, or the top code of the resolution, 0xfff at twelve bits.
  assign comp_out = held_ff >= $signed({4'h0, dac_in});
endmodule

/* File: tb/tb_sqc_seq_ctrl.sv */
// Self-checking bench for the converter sequence controller.
`timescale 1ns/10ps
module tb_sqc_seq_ctrl;
  import sqc_pkg::*;
  logic              ref_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [7:0]        addr = 8'h00;
  logic [31:0]       wdata = 32'h0;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic [1:0]        pin_trig = 2'h0;
  logic              conv_clk = 1'b0;
  logic              comp;
  logic [31:0]       rdata;
  logic [3:0]        chan;
  logic              temp_sel;
  logic              smp;
  logic [11:0]       dac;
  logic              busy;
  logic              irq0;
  logic              irq1;
  logic              irq_th;
  logic [12:0][15:0] vin;
  int                error_cnt = 0;
  int                compares = 0;
  int                seed = 32'h313b;

  // Conversion clock well below five times the system clock.
  always #20 ref_clk = ~ref_clk;
  always #55 conv_clk = ~conv_clk;

  sqc_seq_ctrl #(.NUM_CHAN(12)) uut (
    .REF_CLK_IN(ref_clk), .SYS_RST_IN(sys_rst), .ADDR_IN(addr),
    .WR_DATA_IN(wdata), .WR_EN_IN(wr_en), .RD_EN_IN(rd_en),
    .PIN_TRIG_IN(pin_trig), .CONV_CLK_IN(conv_clk), .COMP_IN(comp),
    .RD_DATA_OUT(rdata), .CHAN_SEL_OUT(chan), .TEMP_SEL_OUT(temp_sel),
    .SAMPLE_OUT(smp), .DAC_CODE_OUT(dac), .BUSY_OUT(busy),
    .SEQ0_IRQ_OUT(irq0), .SEQ1_IRQ_OUT(irq1), .THCMP_IRQ_OUT(irq_th));

  sqc_adc_model u_adc (
    .clk_in(ref_clk), .chan_in(chan), .temp_in(temp_sel),
    .sample_in(smp), .dac_in(dac), .vin_in(vin), .comp_out(comp));

  // --------------------------------------------------------------
  // Reference model and bus tasks
  // --------------------------------------------------------------
  // The code is the floor of the kept top bits.
  function automatic logic [11:0] exp_code(input int v, input int bits);
    int s;
    s = v < 0 ? 0 : (v > 4095 ? 4095 : v);
    return 12'(s) & (12'hfff << (12 - bits));
  endfunction

  function automatic logic [31:0] seqw(input logic [11:0] m,
      input logic [1:0] t, input logic b, input logic s);
    return {1'b1, 4'h0, s, 9'h0, b, 2'h0, t, m};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  // Read data are valid only in the cycle after the strobe.
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic start(input int s, input int ch);
    wr_reg(s ? OFS_SEQ1 : OFS_SEQ0, seqw(12'(1 << ch), 2'h0, 1'b0, 1'b1));
  endtask

  // Held four clocks so the synchroniser sees the edge.
  task automatic pulse(input int i);
    @(posedge ref_clk);
    pin_trig[i] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pin_trig[i] <= 1'b0;
  endtask

  task automatic wait_irq(input int s, output int n);
    n = 0;
    while ((s != 0 ? irq1 : irq0) !== 1'b1 && n < 500) begin
      @(posedge ref_clk) #1 n++;
    end
    if (n >= 500) chk("irq wait", 32'h1, 32'h0);
  endtask

  // Waits for one result, checks both result registers, clears the flag.
  task automatic conv(input int s, input int ch, input int vi,
      input int bits, input logic ovr, output int n);
    logic [31:0] d;
    logic [11:0] c;
    c = exp_code($signed(vin[vi]), bits);
    wait_irq(s, n);
    rd_reg(s ? OFS_GRES1 : OFS_GRES0, d);
    chk("sequence result", {2'h2, 4'(ch), 10'h0, c, 4'h0},
        d & 32'hbc00fff0);
    rd_reg(8'(OFS_DAT0 + 4 * ch), d);
    chk("channel data", {1'b1, ovr, 4'(ch), 10'h0, c, 4'h0},
        d & 32'hfc00fff0);
    wr_reg(OFS_FLAGS, 32'h1 << (FLG_SEQ_LSB + s));
    tick(3);
    chk("sequence irq", 32'h0, {31'h0, s ? irq1 : irq0});
  endtask

  task automatic end_of_test;
    $display("Compares %0d, errors %0d.", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    int n0;
    int n1;
    int n2;
    logic [31:0] d;
    for (int i = 0; i < 13; i++) vin[i] = 16'($random(seed) & 32'hfff);
    vin[1] = 16'hfffb;
    vin[2] = 16'h1388;
    vin[3] = 16'h0800;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_reg(OFS_CTRL, d);
    chk("control reset", 32'h600, d);
    rd_reg(OFS_INSRC, d);
    chk("select reset", 32'h0, d);
    rd_reg(OFS_FLAGS, d);
    chk("flags reset", 32'h0, d);
    wr_reg(8'h7c, $random(seed));
    rd_reg(8'h7c, d);
    chk("unmapped read", 32'h0, d);
    wr_reg(OFS_INTEN, 32'h3);
    for (int ch = 0; ch < 12; ch++) begin
      start(0, ch);
      conv(0, ch, ch, 12, 1'b0, n0);
    end
    wr_reg(OFS_INSRC, {30'h0, INSRC_TEMP});
    tick(2);
    chk("sensor routed", 32'h1, {31'h0, temp_sel});
    start(0, 0);
    conv(0, 0, 12, 12, 1'b0, n0);
    wr_reg(OFS_INSRC, 32'h0);
    tick(2);
    chk("pin routed", 32'h0, {31'h0, temp_sel});
    wr_reg(OFS_SEQ1, seqw(12'h020, TRIG_PIN1, 1'b0, 1'b0));
    wr_reg(OFS_SEQ0, seqw(12'h008, TRIG_PIN0, 1'b0, 1'b0));
    pulse(1);
    conv(1, 5, 5, 12, 1'b0, n0);
    rd_reg(OFS_FLAGS, d);
    chk("first seq idle", 32'h0, {31'h0, d[FLG_SEQ_LSB]});
    pulse(0);
    conv(0, 3, 3, 12, 1'b0, n0);
    start(0, 4);
    conv(0, 4, 4, 12, 1'b0, n0);
    wr_reg(OFS_CTRL, 32'h0);
    start(0, 4);
    conv(0, 4, 4, 6, 1'b0, n1);
    chk("six bit saving", 32'h6, 32'(n0 - n1));
    wr_reg(OFS_CTRL, 32'h603);
    start(0, 4);
    conv(0, 4, 4, 12, 1'b0, n2);
    chk("divided ticks", 32'h1, {31'h0, (n2 - n0) inside {[42:48]}});
    wr_reg(OFS_CTRL, 32'h700);
    start(0, 6);
    conv(0, 6, 6, 12, 1'b0, n0);
    pulse(1);
    conv(1, 5, 5, 12, 1'b0, n0);
    wr_reg(OFS_CTRL, 32'h600);
    wr_reg(OFS_INTEN, 32'h9);
    start(0, 3);
    wait_irq(0, n0);
    wr_reg(OFS_FLAGS, 32'h1 << FLG_SEQ_LSB);
    start(0, 3);
    conv(0, 3, 3, 12, 1'b1, n0);
    rd_reg(OFS_FLAGS, d);
    chk("overrun flag", 32'h1, {31'h0, d[FLG_OVR_LSB + 3]});
    chk("overrun irq", 32'h1, {31'h0, irq_th});
    wr_reg(OFS_FLAGS, 32'h30ffffff);
    tick(3);
    chk("overrun irq clear", 32'h0, {31'h0, irq_th});
    wr_reg(OFS_INTEN, 32'h7);
    start(0, 3);
    conv(0, 3, 3, 12, 1'b0, n0);
    chk("above high irq", 32'h1, {31'h0, irq_th});
    wr_reg(OFS_FLAGS, 32'h30ffffff);
    wr_reg(OFS_THHI0, 32'hfff);
    start(0, 3);
    conv(0, 3, 3, 12, 1'b0, n0);
    rd_reg(OFS_FLAGS, d);
    chk("inside window", 32'h0, {31'h0, d[3]});
    wr_reg(OFS_SEQ1, seqw(12'h080, 2'h0, 1'b1, 1'b0));
    conv(1, 7, 7, 12, 1'b0, n0);
    conv(1, 7, 7, 12, 1'b0, n0);
    wr_reg(OFS_SEQ1, 32'h0);
    tick(40);
    chk("burst stopped", 32'h0, {31'h0, busy});
    end_of_test;
  end

  // Watchdog: the scenarios need a few thousand clocks at most.
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    end_of_test;
  end
endmodule
